// [rtl/alu_exec_consts.vh]
// constants for the alu and branch execution block
// assumes one core clock; included by bare name
`ifndef ALU_EXEC_CONSTS_VH
`define ALU_EXEC_CONSTS_VH

// status flag bit positions
`define F_C 0
`define F_Z 1
`define F_N 2
`define F_V 3
`define F_S 4
`define F_H 5
`define F_T 6
`define F_I 7

// operation codes from the decoder
`define OP_ADD      6'h00
`define OP_ADC      6'h01
`define OP_SUB      6'h02
`define OP_SBC      6'h03
`define OP_AND      6'h04
`define OP_OR       6'h05
`define OP_EOR      6'h06
`define OP_SETM     6'h07
`define OP_CLRM     6'h08
`define OP_TEST     6'h09
`define OP_CP       6'h0A
`define OP_CPC      6'h0B
`define OP_ADDW     6'h0C
`define OP_SUBW     6'h0D
`define OP_REL_JUMP 6'h0E
`define OP_PJMP     6'h0F
`define OP_REL_CALL 6'h10
`define OP_PCALL    6'h11
`define OP_CPSKIP   6'h12
`define OP_SK_RCLR  6'h13
`define OP_SK_RSET  6'h14
`define OP_SK_ICLR  6'h15
`define OP_SK_ISET  6'h16
`define OP_BR_FSET  6'h17
`define OP_BR_FCLR  6'h18
`define OP_BR_EQ    6'h19
`define OP_BR_NE    6'h1A
`define OP_BR_CS    6'h1B
`define OP_BR_CC    6'h1C
`define OP_BR_SH    6'h1D
`define OP_BR_LO    6'h1E
`define OP_BR_MI    6'h1F
`define OP_BR_PL    6'h20
`define OP_BR_GE    6'h21
`define OP_BR_LT    6'h22
`define OP_BR_HS    6'h23
`define OP_BR_HC    6'h24
`define OP_BR_TS    6'h25
`define OP_BR_TC    6'h26
`define OP_BR_VS    6'h27
`define OP_BR_VC    6'h28
`define OP_BR_IE    6'h29
`define OP_BR_ID    6'h2A

// cycle counts
`define CYC_ONE   2'h1
`define CYC_TWO   2'h2
`define CYC_THREE 2'h3

// reset values
`define RST_BYTE  8'h00
`define RST_WORD  16'h0000
`define RST_CNT   2'h0

`endif

// [rtl/alu_add8.v]
// 8-bit adder and subtractor with carry, half carry and overflow
// assumes purely combinational use inside the execution block
`timescale 1ns/10ps
`default_nettype none

module alu_add8
(
	// operands
	input  wire [7:0] i_a,
	input  wire [7:0] i_b,
	input  wire       i_cin,
	input  wire       i_sub,
	// results
	output wire [7:0] o_res,
	output wire       o_carry,
	output wire       o_half,
	output wire       o_ovf
);

	wire [7:0] b_eff;
	wire       c_eff;
	wire [8:0] full_sum;
	wire [4:0] low_sum;

	// subtract as a plus inverted b plus inverted borrow
	assign b_eff    = i_sub ? ~i_b : i_b;
	assign c_eff    = i_sub ? ~i_cin : i_cin;
	assign full_sum = {1'b0, i_a} + {1'b0, b_eff} + {8'h00, c_eff};
	assign low_sum  = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]}
		+ {4'h0, c_eff};

	assign o_res   = full_sum[7:0];
	// borrow is the inverted carry out
	assign o_carry = full_sum[8] ^ i_sub;
	assign o_half  = low_sum[4] ^ i_sub;
	assign o_ovf   = (i_a[7] == b_eff[7]) && (full_sum[7] != i_a[7]);

endmodule // alu_add8

`default_nettype wire

// [rtl/alu_and_branch_exec.v]
// execution of arithmetic, logic, compare, skip and branch operations
// assumes a decoder that hands over operands and a register file,
// status flags and program counter that take the registered results
`timescale 1ns/10ps
`default_nettype none
`include "alu_exec_consts.vh"

module alu_and_branch_exec
(
	// clock and reset
	input  wire        i_core_clk,
	input  wire        i_srst,
	// request from decoder
	input  wire        i_start,
	input  wire [5:0]  i_op,
	input  wire [7:0]  i_opa,
	input  wire [7:0]  i_opb,
	input  wire [7:0]  i_opa_hi,
	input  wire [5:0]  i_word_k,
	input  wire [11:0] i_offset,
	input  wire [2:0]  i_flag_sel,
	input  wire [2:0]  i_bit_sel,
	input  wire [7:0]  i_io_val,
	input  wire        i_next_long,
	// core state
	input  wire [15:0] i_pc,
	input  wire [15:0] i_z_ptr,
	input  wire [7:0]  i_status,
	// handshake
	output reg         o_busy,
	output reg         o_done,
	// register file
	output reg         o_rd_we,
	output reg  [7:0]  o_rd_data,
	output reg         o_pair_we,
	output reg  [15:0] o_pair_data,
	// status flags
	output reg         o_status_we,
	output reg  [7:0]  o_status,
	// program counter and stack
	output reg  [15:0] o_pc,
	output reg         o_push_we,
	output reg  [15:0] o_push_data
);

	// ************************************************************
	// functions
	// ************************************************************

	// flags of an arithmetic result
	function [7:0] arith_flags;
		input [7:0] old;
		input [7:0] res;
		input       c;
		input       h;
		input       v;
		input       chain;
		reg   [7:0] f;
		begin
			f = old;
			f[`F_C] = c;
			f[`F_Z] = (res == 8'h00) & (~chain | old[`F_Z]);
			f[`F_N] = res[7];
			f[`F_V] = v;
			f[`F_H] = h;
			arith_flags = f;
		end
	endfunction

	// flags of a logic result, carry and half carry kept
	function [7:0] logic_flags;
		input [7:0] old;
		input [7:0] res;
		reg   [7:0] f;
		begin
			f = old;
			f[`F_Z] = (res == 8'h00);
			f[`F_N] = res[7];
			f[`F_V] = 1'b0;
			logic_flags = f;
		end
	endfunction

	// relative target pc plus offset plus one
	function [15:0] rel_target;
		input [15:0] pc;
		input [11:0] off;
		begin
			rel_target = pc + {{4{off[11]}}, off} + 16'h0001;
		end
	endfunction

	// condition of every branch form
	function branch_hit;
		input [5:0] op;
		input [2:0] sel;
		input [7:0] f;
		begin
			case (op)
				`OP_BR_FSET: branch_hit = f[sel];
				`OP_BR_FCLR: branch_hit = ~f[sel];
				`OP_BR_EQ:   branch_hit = f[`F_Z];
				`OP_BR_NE:   branch_hit = ~f[`F_Z];
				`OP_BR_CS:   branch_hit = f[`F_C];
				`OP_BR_CC:   branch_hit = ~f[`F_C];
				`OP_BR_SH:   branch_hit = ~f[`F_C];
				`OP_BR_LO:   branch_hit = f[`F_C];
				`OP_BR_MI:   branch_hit = f[`F_N];
				`OP_BR_PL:   branch_hit = ~f[`F_N];
				`OP_BR_GE:   branch_hit = ~(f[`F_N] ^ f[`F_V]);
				`OP_BR_LT:   branch_hit = f[`F_N] ^ f[`F_V];
				`OP_BR_HS:   branch_hit = f[`F_H];
				`OP_BR_HC:   branch_hit = ~f[`F_H];
				`OP_BR_TS:   branch_hit = f[`F_T];
				`OP_BR_TC:   branch_hit = ~f[`F_T];
				`OP_BR_VS:   branch_hit = f[`F_V];
				`OP_BR_VC:   branch_hit = ~f[`F_V];
				`OP_BR_IE:   branch_hit = f[`F_I];
				`OP_BR_ID:   branch_hit = ~f[`F_I];
				default:     branch_hit = 1'b0;
			endcase
		end
	endfunction

	// ************************************************************
	// adder
	// ************************************************************

	wire       add_sub;
	wire       add_cin;
	wire [7:0] add_res;
	wire       add_c;
	wire       add_h;
	wire       add_v;

	assign add_sub = (i_op == `OP_SUB) || (i_op == `OP_SBC)
		|| (i_op == `OP_CP) || (i_op == `OP_CPC);
	assign add_cin = ((i_op == `OP_ADC) || (i_op == `OP_SBC)
		|| (i_op == `OP_CPC)) & i_status[`F_C];

	alu_add8 u_add8
	(
		.i_a     (i_opa),
		.i_b     (i_opb),
		.i_cin   (add_cin),
		.i_sub   (add_sub),
		.o_res   (add_res),
		.o_carry (add_c),
		.o_half  (add_h),
		.o_ovf   (add_v)
	);

	// ************************************************************
	// word arithmetic
	// ************************************************************

	wire [15:0] pair_in;
	wire [15:0] pair_add;
	wire [15:0] pair_sub;

	assign pair_in  = {i_opa_hi, i_opa};
	assign pair_add = pair_in + {10'h000, i_word_k};
	assign pair_sub = pair_in - {10'h000, i_word_k};

	// ************************************************************
	// next values
	// ************************************************************

	wire [15:0] pc_inc;
	wire [15:0] pc_rel;
	wire [15:0] pc_skip;

	assign pc_inc  = i_pc + 16'h0001;
	assign pc_rel  = rel_target(i_pc, i_offset);
	assign pc_skip = i_pc + (i_next_long ? 16'h0003 : 16'h0002);

	reg  [7:0]  rd_nxt;
	reg         rd_we_nxt;
	reg  [15:0] pair_nxt;
	reg         pair_we_nxt;
	reg  [7:0]  status_nxt;
	reg         status_we_nxt;
	reg  [15:0] pc_nxt;
	reg         push_we_nxt;
	reg  [1:0]  cyc_nxt;
	reg         skip_c;
	reg  [15:0] wres_c;
	reg         wneg_c;

	always @*
	begin
		rd_nxt      = i_opa;
		rd_we_nxt   = 1'b0;
		pair_nxt    = pair_in;
		pair_we_nxt = 1'b0;
		status_nxt    = i_status;
		status_we_nxt = 1'b0;
		pc_nxt      = pc_inc;
		push_we_nxt = 1'b0;
		cyc_nxt     = `CYC_ONE;
		skip_c      = 1'b0;
		wres_c      = pair_add;
		wneg_c      = 1'b0;
		case (i_op)
			`OP_ADD, `OP_ADC:
			begin
				rd_nxt        = add_res;
				rd_we_nxt     = 1'b1;
				status_nxt    = arith_flags(i_status, add_res, add_c,
					add_h, add_v, 1'b0);
				status_we_nxt = 1'b1;
			end
			`OP_SUB, `OP_SBC:
			begin
				rd_nxt        = add_res;
				rd_we_nxt     = 1'b1;
				status_nxt    = arith_flags(i_status, add_res, add_c,
					add_h, add_v, i_op == `OP_SBC);
				status_we_nxt = 1'b1;
			end
			`OP_CP, `OP_CPC:
			begin
				status_nxt    = arith_flags(i_status, add_res, add_c,
					add_h, add_v, i_op == `OP_CPC);
				status_we_nxt = 1'b1;
			end
			`OP_AND, `OP_OR, `OP_EOR:
			begin
				if (i_op == `OP_AND)
					rd_nxt = i_opa & i_opb;
				else if (i_op == `OP_OR)
					rd_nxt = i_opa | i_opb;
				else
					rd_nxt = i_opa ^ i_opb;
				rd_we_nxt     = 1'b1;
				status_nxt    = logic_flags(i_status, rd_nxt);
				status_we_nxt = 1'b1;
			end
			`OP_SETM, `OP_CLRM:
			begin
				if (i_op == `OP_SETM)
					rd_nxt = i_opa | i_opb;
				else
					rd_nxt = i_opa & ~i_opb;
				rd_we_nxt     = 1'b1;
				status_nxt    = logic_flags(i_status, rd_nxt);
				status_we_nxt = 1'b1;
			end
			`OP_TEST:
			begin
				rd_nxt        = i_opa & i_opa;
				status_nxt    = logic_flags(i_status, rd_nxt);
				status_we_nxt = 1'b1;
			end
			`OP_ADDW, `OP_SUBW:
			begin
				if (i_op == `OP_ADDW)
				begin
					wres_c = pair_add;
					wneg_c = 1'b0;
				end
				else
				begin
					wres_c = pair_sub;
					wneg_c = 1'b1;
				end
				pair_nxt    = wres_c;
				pair_we_nxt = 1'b1;
				status_nxt[`F_Z] = (wres_c == 16'h0000);
				status_nxt[`F_N] = wres_c[15];
				status_nxt[`F_V] = wneg_c ? (i_opa_hi[7] & ~wres_c[15])
					: (~i_opa_hi[7] & wres_c[15]);
				status_nxt[`F_C] = wneg_c ? (wres_c[15] & ~i_opa_hi[7])
					: (~wres_c[15] & i_opa_hi[7]);
				status_nxt[`F_S] = status_nxt[`F_N] ^ status_nxt[`F_V];
				status_we_nxt = 1'b1;
				cyc_nxt     = `CYC_TWO;
			end
			`OP_REL_JUMP, `OP_PJMP:
			begin
				pc_nxt  = (i_op == `OP_REL_JUMP) ? pc_rel : i_z_ptr;
				cyc_nxt = `CYC_TWO;
			end
			`OP_REL_CALL, `OP_PCALL:
			begin
				pc_nxt      = (i_op == `OP_REL_CALL) ? pc_rel : i_z_ptr;
				push_we_nxt = 1'b1;
				cyc_nxt     = `CYC_THREE;
			end
			`OP_CPSKIP:
				skip_c = (i_opa == i_opb);
			`OP_SK_RCLR, `OP_SK_RSET:
				skip_c = i_opa[i_bit_sel] == (i_op == `OP_SK_RSET);
			`OP_SK_ICLR, `OP_SK_ISET:
				skip_c = i_io_val[i_bit_sel] == (i_op == `OP_SK_ISET);
			default:
			begin
				// relative branch taken
				if (branch_hit(i_op, i_flag_sel, i_status))
				begin
					pc_nxt  = pc_rel;
					cyc_nxt = `CYC_TWO;
				end
			end
		endcase
		if (skip_c)
		begin
			pc_nxt  = pc_skip;
			cyc_nxt = i_next_long ? `CYC_THREE : `CYC_TWO;
		end
	end

	// ************************************************************
	// sequencing and output registers
	// ************************************************************

	reg  [1:0]  cnt_r;
	reg         rd_we_r;
	reg         pair_we_r;
	reg         status_we_r;
	reg         push_we_r;

	always @(posedge i_core_clk)
	begin
		if (i_srst)
		begin
			o_busy      <= 1'b0;
			o_done      <= 1'b0;
			o_rd_we     <= 1'b0;
			o_rd_data   <= `RST_BYTE;
			o_pair_we   <= 1'b0;
			o_pair_data <= `RST_WORD;
			o_status_we <= 1'b0;
			o_status    <= `RST_BYTE;
			o_pc        <= `RST_WORD;
			o_push_we   <= 1'b0;
			o_push_data <= `RST_WORD;
			cnt_r       <= `RST_CNT;
			rd_we_r     <= 1'b0;
			pair_we_r   <= 1'b0;
			status_we_r <= 1'b0;
			push_we_r   <= 1'b0;
		end
		else
		begin
			o_done    <= 1'b0;
			o_rd_we   <= 1'b0;
			o_pair_we <= 1'b0;
			o_status_we <= 1'b0;
			o_push_we <= 1'b0;
			if (i_start && !o_busy)
			begin
				o_rd_data   <= rd_nxt;
				o_pair_data <= pair_nxt;
				o_status    <= status_nxt;
				o_pc        <= pc_nxt;
				o_push_data <= pc_inc;
				if (cyc_nxt == `CYC_ONE)
				begin
					o_done    <= 1'b1;
					o_rd_we   <= rd_we_nxt;
					o_pair_we <= pair_we_nxt;
					o_status_we <= status_we_nxt;
					o_push_we <= push_we_nxt;
				end
				else
				begin
					o_busy    <= 1'b1;
					cnt_r     <= cyc_nxt - `CYC_ONE;
					rd_we_r   <= rd_we_nxt;
					pair_we_r <= pair_we_nxt;
					status_we_r <= status_we_nxt;
					push_we_r <= push_we_nxt;
				end
			end
			else if (o_busy)
			begin
				cnt_r <= cnt_r - `CYC_ONE;
				// last cycle releases strobes
				if (cnt_r == `CYC_ONE)
				begin
					o_busy    <= 1'b0;
					o_done    <= 1'b1;
					o_rd_we   <= rd_we_r;
					o_pair_we <= pair_we_r;
					o_status_we <= status_we_r;
					o_push_we <= push_we_r;
				end
			end
		end
	end

endmodule // alu_and_branch_exec

`default_nettype wire

// [tb/alu_exec_props_properties.sv]
// assertions on the execution block ports
// assumes one core clock and the sync reset
`timescale 1ns/10ps
`default_nettype none
`include "alu_exec_consts.vh"
module alu_exec_props
(
	// clock and request
	input wire logic        i_core_clk,
	input wire logic        i_srst,
	input wire logic        i_start,
	input wire logic [5:0]  i_op,
	input wire logic [15:0] i_pc,
	input wire logic [15:0] i_z_ptr,
	input wire logic [7:0]  i_status,
	// results
	input wire logic        o_busy,
	input wire logic        o_done,
	input wire logic        o_rd_we,
	input wire logic        o_pair_we,
	input wire logic        o_status_we,
	input wire logic [7:0]  o_status,
	input wire logic [15:0] o_pc,
	input wire logic        o_push_we,
	input wire logic [15:0] o_push_data
);
	// ****
	// properties
	// ****
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_srst);
	wire logic acc = i_start && !o_busy;
	add_one_cyc_a: assert property (
		acc && i_op == `OP_ADD |=> o_done && o_rd_we && o_status_we)
		else $error("add not done in one cycle");
	word_two_cyc_a: assert property (
		acc && (i_op == `OP_ADDW || i_op == `OP_SUBW)
		|=> o_busy && !o_done ##1 o_done && o_pair_we && !o_busy)
		else $error("word op not done in two cycles");
	sub_keeps_s_a: assert property (
		acc && (i_op == `OP_SUB || i_op == `OP_SBC) |=> o_done
		&& o_rd_we && o_status[`F_S] == $past(i_status[`F_S]))
		else $error("subtract timing or sign flag wrong");
	logic_keep_a: assert property (
		acc && (i_op == `OP_AND || i_op == `OP_EOR)
		|=> !o_status[`F_V]
		&& o_status[`F_C] == $past(i_status[`F_C])
		&& o_status[`F_H] == $past(i_status[`F_H]))
		else $error("logic op flags wrong");
	test_no_wr_a: assert property (
		acc && i_op == `OP_TEST |=> o_done && !o_rd_we && o_status_we)
		else $error("test wrote a register");
	cmp_no_wr_a: assert property (
		acc && (i_op == `OP_CP || i_op == `OP_CPC)
		|=> o_done && !o_rd_we && !o_pair_we && o_status_we)
		else $error("compare wrote a register");
	pjump_z_a: assert property (
		acc && i_op == `OP_PJMP
		|=> o_busy ##1 o_done && o_pc == $past(i_z_ptr, 2))
		else $error("pointer jump target or timing wrong");
	call_push_a: assert property (
		acc && i_op == `OP_REL_CALL |=> o_busy [*2] ##1 o_done
		&& o_push_we && o_push_data == $past(i_pc, 3) + 16'h0001)
		else $error("call push wrong");
	skip_no_flag_a: assert property (
		acc && i_op >= `OP_CPSKIP && i_op <= `OP_SK_ISET
		|-> ##[1:3] o_done && !o_status_we)
		else $error("skip changed flags or hung");
	br_no_flag_a: assert property (
		acc && i_op >= `OP_BR_FSET && i_op <= `OP_BR_ID
		|-> ##[1:2] o_done && !o_status_we)
		else $error("branch changed flags or hung");
	cover property (acc && i_op == `OP_REL_CALL);
	cover property (acc && i_op == `OP_ADDW);
	cover property (acc && i_op == `OP_BR_EQ ##1 o_busy);
endmodule // alu_exec_props
bind alu_and_branch_exec alu_exec_props u_props (.i_core_clk, .i_srst,
	.i_start, .i_op, .i_pc, .i_z_ptr, .i_status, .o_busy, .o_done,
	.o_rd_we, .o_pair_we, .o_status_we, .o_status, .o_pc, .o_push_we,
	.o_push_data);
`default_nettype wire

// [tb/core_state_model.sv]
// program counter and flag holder of the core
// assumes the bench loads start values between operations
`timescale 1ns/10ps
`default_nettype none
module core_state_model
(
	// clock and load
	input wire logic         i_core_clk,
	input wire logic         i_srst,
	input wire logic         i_ld,
	input wire logic [15:0]  i_ld_pc,
	input wire logic [7:0]   i_ld_status,
	// results taken back
	input wire logic         i_done,
	input wire logic [15:0]  i_new_pc,
	input wire logic         i_status_we,
	input wire logic [7:0]   i_new_status,
	// state seen by the block
	output var logic [15:0]  o_pc,
	output var logic [7:0]   o_status
);
	always @(posedge i_core_clk)
	begin
		if (i_srst || i_ld)
		begin
			o_pc <= i_srst ? 16'h0000 : i_ld_pc;
			o_status <= i_srst ? 8'h00 : i_ld_status;
		end
		else
		begin
			if (i_done)
				o_pc <= i_new_pc;
			if (i_status_we)
				o_status <= i_new_status;
		end
	end
endmodule // core_state_model
`default_nettype wire

// [tb/alu_and_branch_exec_tb.sv]
// self-checking bench for the execution block
// assumes the state model feeds pc and flags
`timescale 1ns/10ps
`default_nettype none
`include "alu_exec_consts.vh"
module alu_and_branch_exec_tb;
	logic i_core_clk, i_srst, i_start, i_next_long, ld;
	logic [5:0] i_op, i_word_k;
	logic [7:0] i_opa, i_opb, i_opa_hi, i_io_val, ld_s;
	logic [11:0] i_offset;
	logic [2:0] i_flag_sel, i_bit_sel;
	logic [15:0] i_z_ptr, ld_pc, o_pair_data, o_pc, o_push_data;
	wire logic [15:0] cur_pc;
	wire logic [7:0] cur_s;
	logic o_busy, o_done, o_rd_we, o_pair_we, o_status_we, o_push_we;
	logic [7:0] o_rd_data, o_status;
	logic [3:0] we, cyc;
	int miscompares, comparisons;
	alu_and_branch_exec uut (.i_core_clk, .i_srst, .i_start, .i_op, .i_opa,
		.i_opb, .i_opa_hi, .i_word_k, .i_offset, .i_flag_sel, .i_bit_sel,
		.i_io_val, .i_next_long, .i_pc(cur_pc), .i_z_ptr,
		.i_status(cur_s), .o_busy, .o_done, .o_rd_we, .o_rd_data,
		.o_pair_we, .o_pair_data, .o_status_we, .o_status, .o_pc,
		.o_push_we, .o_push_data);
	core_state_model u_state (.i_core_clk, .i_srst, .i_ld(ld),
		.i_ld_pc(ld_pc), .i_ld_status(ld_s), .i_done(o_done),
		.i_new_pc(o_pc), .i_status_we(o_status_we),
		.i_new_status(o_status), .o_status(cur_s), .o_pc(cur_pc));
	initial
	begin
		i_core_clk = 1'b0;
		forever #50 i_core_clk = ~i_core_clk;
	end
	// ****
	// helpers
	// ****
	task summarize;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task ld_state(input logic [15:0] p, input logic [7:0] s);
		ld = 1'b1;
		ld_pc = p;
		ld_s = s;
		@(negedge i_core_clk);
		ld = 1'b0;
	endtask
	task run(input logic [5:0] op);
		i_op = op;
		i_start = 1'b1;
		@(negedge i_core_clk);
		i_start = 1'b0;
		cyc = 4'h1;
		while (o_done !== 1'b1 && cyc < 4'h6)
		begin
			@(negedge i_core_clk);
			cyc++;
		end
		we = {o_rd_we, o_pair_we, o_status_we, o_push_we};
		if (o_done !== 1'b1)
		begin
			miscompares++;
			summarize();
		end
	endtask
	task alu(input logic [5:0] op, input logic [7:0] a, b, s, r, es,
		input logic [3:0] ew);
		ld_state(16'h0040, s);
		i_opa = a;
		i_opb = b;
		run(op);
		if (ew[3])
			chk("rd_data", o_rd_data, r);
		chk("flags", o_status, es);
		chk("strobes", we, ew);
		chk("cycles", cyc, 4'h1);
	endtask
	task jmp(input logic [5:0] op, input logic [15:0] p, ep,
		input logic [3:0] ec, ew);
		ld_state(p, 8'h00);
		run(op);
		chk("pc", o_pc, ep);
		chk("cycles", cyc, ec);
		chk("strobes", we, ew);
	endtask
	// ****
	// scenarios
	// ****
	task t_arith;
		alu(`OP_ADD, 8'h38, 8'h08, 8'h50, 8'h40, 8'h70, 4'hA);
		alu(`OP_ADC, 8'hFF, 8'h00, 8'h01, 8'h00, 8'h23, 4'hA);
		alu(`OP_SUB, 8'h80, 8'h01, 8'h00, 8'h7F, 8'h28, 4'hA);
		alu(`OP_SBC, 8'h05, 8'h04, 8'h03, 8'h00, 8'h02, 4'hA);
		alu(`OP_SBC, 8'h05, 8'h04, 8'h01, 8'h00, 8'h00, 4'hA);
		alu(`OP_TEST, 8'h00, 8'h00, 8'h08, 8'h00, 8'h02, 4'h2);
		alu(`OP_CP, 8'h10, 8'h20, 8'h00, 8'h00, 8'h05, 4'h2);
		alu(`OP_CPC, 8'h10, 8'h0F, 8'h03, 8'h00, 8'h22, 4'h2);
	endtask
	task t_logic;
		logic [5:0] ops [5];
		logic [7:0] res [5];
		ops = '{`OP_AND, `OP_OR, `OP_EOR, `OP_SETM, `OP_CLRM};
		res = '{8'h80, 8'hFF, 8'h7F, 8'hFF, 8'h70};
		for (int i = 0; i < 5; i++)
			alu(ops[i], 8'hF0, 8'h8F, 8'h29, res[i],
				{5'h04, res[i][7], 2'h1}, 4'hA);
	endtask
	task t_word;
		ld_state(16'h0000, 8'h00);
		{i_opa_hi, i_opa, i_word_k} = {16'h00FF, 6'h3F};
		run(`OP_ADDW);
		chk("pair", o_pair_data, 16'h013E);
		chk("wflags", o_status, 8'h00);
		chk("wcyc", {we, cyc}, 8'h62);
		ld_state(16'h0000, 8'h00);
		{i_opa_hi, i_opa, i_word_k} = {16'h0000, 6'h01};
		run(`OP_SUBW);
		chk("pair", o_pair_data, 16'hFFFF);
		chk("wflags", o_status, 8'h15);
	endtask
	task t_jump;
		{i_offset, i_z_ptr} = {12'hFFE, 16'h1234};
		jmp(`OP_REL_JUMP, 16'h0100, 16'h00FF, 4'h2, 4'h0);
		jmp(`OP_PJMP, 16'h0100, 16'h1234, 4'h2, 4'h0);
		i_offset = 12'h005;
		jmp(`OP_REL_CALL, 16'h0010, 16'h0016, 4'h3, 4'h1);
		chk("push", o_push_data, 16'h0011);
		jmp(`OP_PCALL, 16'h0020, 16'h1234, 4'h3, 4'h1);
		chk("push", o_push_data, 16'h0021);
	endtask
	task t_skip;
		{i_opa, i_opb, i_next_long} = {8'h05, 8'h05, 1'b0};
		jmp(`OP_CPSKIP, 16'h0100, 16'h0102, 4'h2, 4'h0);
		i_next_long = 1'b1;
		jmp(`OP_CPSKIP, 16'h0100, 16'h0103, 4'h3, 4'h0);
		i_opb = 8'h06;
		jmp(`OP_CPSKIP, 16'h0100, 16'h0101, 4'h1, 4'h0);
		{i_opa, i_opb, i_io_val, i_bit_sel} = {24'h040404, 3'h2};
		i_next_long = 1'b0;
		jmp(`OP_SK_RSET, 16'h0100, 16'h0102, 4'h2, 4'h0);
		jmp(`OP_SK_RCLR, 16'h0100, 16'h0101, 4'h1, 4'h0);
		jmp(`OP_SK_ISET, 16'h0100, 16'h0102, 4'h2, 4'h0);
		{i_bit_sel, i_next_long} = {3'h3, 1'b1};
		jmp(`OP_SK_ICLR, 16'h0100, 16'h0103, 4'h3, 4'h0);
	endtask
	function logic taken(input logic [5:0] op, input logic [7:0] s);
		case (op)
			`OP_BR_FSET: taken = s[op[2:0]];
			`OP_BR_FCLR: taken = !s[op[2:0]];
			`OP_BR_EQ: taken = s[`F_Z];
			`OP_BR_NE: taken = !s[`F_Z];
			`OP_BR_CS, `OP_BR_LO: taken = s[`F_C];
			`OP_BR_CC, `OP_BR_SH: taken = !s[`F_C];
			`OP_BR_MI: taken = s[`F_N];
			`OP_BR_PL: taken = !s[`F_N];
			`OP_BR_GE: taken = !(s[`F_N] ^ s[`F_V]);
			`OP_BR_LT: taken = s[`F_N] ^ s[`F_V];
			`OP_BR_HS: taken = s[`F_H];
			`OP_BR_HC: taken = !s[`F_H];
			`OP_BR_TS: taken = s[`F_T];
			`OP_BR_TC: taken = !s[`F_T];
			`OP_BR_VS: taken = s[`F_V];
			`OP_BR_VC: taken = !s[`F_V];
			`OP_BR_IE: taken = s[`F_I];
			default: taken = !s[`F_I];
		endcase
	endfunction
	task t_branch;
		logic [7:0] sv [4];
		logic t;
		sv = '{8'h00, 8'hFF, 8'h55, 8'hAA};
		i_offset = 12'hFC0;
		for (logic [5:0] op = `OP_BR_FSET; op <= `OP_BR_ID; op++)
			for (int k = 0; k < 4; k++)
			begin
				t = taken(op, sv[k]);
				i_flag_sel = op[2:0];
				ld_state(16'h0200, sv[k]);
				run(op);
				chk("br_pc", o_pc, t ? 16'h01C1 : 16'h0201);
				chk("br_cyc", {we, cyc}, t ? 8'h02 : 8'h01);
			end // cover the same loop
	endtask
	task t_b2b;
		{i_opa, i_opb, i_op, i_start} = {16'h0101, `OP_ADD, 1'b1};
		@(negedge i_core_clk);
		chk("b2b_1", {o_done, o_rd_data}, 9'h102);
		i_opa = 8'h03;
		@(negedge i_core_clk);
		i_start = 1'b0;
		chk("b2b_2", {o_done, o_rd_data}, 9'h104);
	endtask
	initial
	begin
		{i_srst, i_start, i_next_long, ld, i_op, i_word_k} = 16'h8000;
		{i_opa, i_opb, i_opa_hi, i_io_val, ld_s} = 40'h0;
		{i_offset, i_flag_sel, i_bit_sel, i_z_ptr, ld_pc} = 50'h0;
		repeat (20) @(negedge i_core_clk);
		i_srst = 1'b0;
		chk("rst", {o_busy, o_done, o_pc}, 18'h0);
		t_arith();
		t_logic();
		t_word();
		t_jump();
		t_skip();
		t_branch();
		t_b2b();
		summarize();
	end
endmodule // alu_and_branch_exec_tb
`default_nettype wire
